// >>> rtl/gpd_bank.v
// pin data register bank: six byte-wide data registers, one config byte per pin
// assumes a single APB master on pclk; pin inputs are asynchronous and are
// synchronised here; alternate function logic lives outside on pclk
`timescale 1ns/100ps
`include "gpd_consts.vh"

module gpd_bank #(
   parameter ADDR_W = 12
)
(
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // pins, one slot per data bit
   input wire [47:0] pin_in,
   output reg [47:0] pin_out,
   output reg [47:0] pin_oe,
   // alternate functions, three per slot, slot s uses bits 3*s+k
   input wire [143:0] alt_dout,
   input wire [143:0] alt_doe,
   output reg [47:0] pin_level,
   output reg [95:0] pin_fn
);

localparam [47:0] VALID = `GPD_VALID_MASK;

// word index relative to the programmable block base
function [9:0] rel_index;
   input [ADDR_W-1:0] a;
   input [9:0] b;
   begin
      rel_index = a[ADDR_W-1:2] - b;
   end
endfunction

// true when the relative index falls in [lo, hi]
function in_range;
   input [9:0] r;
   input [9:0] lo;
   input [9:0] hi;
   begin
      in_range = (r >= lo) && (r <= hi);
   end
endfunction

// bit of the alternate buses for function f of slot s; f of zero is gpio
function integer alt_bit;
   input integer s;
   input [1:0] f;
   begin
      alt_bit = 3 * s + f - 1;
   end
endfunction

// registers
reg [9:0] base_reg;
reg [7:0] cfg_reg [0:47];
reg [47:0] data_reg;
reg [47:0] data_next;

// synchronised pin levels
wire [47:0] pin_sync;

gpd_sync #(
   .W(48)
)
u_sync (
   .clk(pclk),
   .rst_n(presetn),
   .d_async(pin_in),
   .q_sync(pin_sync)
);

// decode
wire [9:0] rel;
wire hit_base;
wire hit_data;
wire hit_cfg;
wire [9:0] bank_off;
wire [9:0] cfg_off;
wire [5:0] cfg_slot;
wire cfg_ok;
wire mapped;
wire setup_ph;
wire access_ph;

assign rel = rel_index(paddr, base_reg);
assign hit_base = (paddr[ADDR_W-1:2] == `GPD_IDX_BASE_REG);
assign hit_data = !hit_base && in_range(rel, `GPD_IDX_BANK_ONE, `GPD_IDX_BANK_SIX);
assign hit_cfg = !hit_base && in_range(rel, `GPD_IDX_CFG_FIRST, `GPD_IDX_CFG_LAST);
assign bank_off = rel - `GPD_IDX_BANK_ONE;
assign cfg_off = rel - `GPD_IDX_CFG_FIRST;
assign cfg_slot = cfg_off[5:0];
assign cfg_ok = hit_cfg && VALID[cfg_slot];
assign mapped = hit_base || hit_data || cfg_ok;
assign setup_ph = psel && !penable;
assign access_ph = psel && penable && pready;

// write strobes, taken only in the access cycle, and a bank touch strobe taken in setup or access
wire wr_commit;
wire wr_base;
wire wr_cfg;
wire bank_touch;

assign wr_commit = access_ph && pwrite;
assign wr_base = wr_commit && hit_base;
assign wr_cfg = wr_commit && cfg_ok;
assign bank_touch = setup_ph || access_ph;

// per-slot views of config
reg [47:0] is_input;
reg [47:0] pol;
reg [47:0] pin_view;
integer i;

always @*
begin
   is_input = 48'h000000000000;
   pol = 48'h000000000000;
   pin_view = 48'h000000000000;
   for (i = 0; i < 48; i = i + 1)
   begin
      is_input[i] = cfg_reg[i][`GPD_CFG_DIR];
      pol[i] = cfg_reg[i][`GPD_CFG_POL];
      // input view carries the polarity inversion
      pin_view[i] = VALID[i] & (pin_sync[i] ^ cfg_reg[i][`GPD_CFG_POL]);
   end
end

// byte image of the addressed bank as software should see it
reg [7:0] bank_rd;
reg [47:0] bank_sel;
integer j;

always @*
begin
   bank_rd = 8'h00;
   bank_sel = 48'h000000000000;
   for (j = 0; j < 48; j = j + 1)
   begin
      if (hit_data && (j / 8 == bank_off) && VALID[j])
      begin
         bank_sel[j] = 1'b1;
         if (is_input[j])
            bank_rd[j % 8] = pin_view[j];
         else
            bank_rd[j % 8] = data_reg[j];
      end
   end
end

// data latch: input bits sample the pin on every read and write of their
// bank, output bits take software writes only
integer k;

always @*
begin
   data_next = data_reg;
   for (k = 0; k < 48; k = k + 1)
   begin
      if (bank_sel[k] && is_input[k] && bank_touch)
         data_next[k] = pin_view[k];
      else if (bank_sel[k] && !is_input[k] && wr_commit)
         data_next[k] = pwdata[k % 8];
      // writes to input bits fall through untouched
   end
   data_next = data_next & VALID;
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      data_reg <= 48'h000000000000;
   else
      data_reg <= data_next;
end

// configuration bytes, one per pin
integer m;

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      for (m = 0; m < 48; m = m + 1)
      begin
         if (m == `GPD_SLOT_IR_RX || m == `GPD_SLOT_IR_TX)
            cfg_reg[m] <= `GPD_CFG_RESET_IR;
         else
            cfg_reg[m] <= `GPD_CFG_RESET;
      end
   end
   else if (wr_cfg)
   begin
      cfg_reg[cfg_slot] <= pwdata[7:0];
   end
end

// block base, relocatable by software
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      base_reg <= `GPD_BASE_RESET;
   else if (wr_base)
      base_reg <= pwdata[9:0];
end

// apb answer: no wait states, data and error prepared in the setup cycle
// so that every bus output comes straight from a flop
reg [31:0] rd_word;

always @*
begin
   rd_word = 32'h00000000;
   if (hit_base)
      rd_word = {22'h000000, base_reg};
   else if (hit_data)
      rd_word = {24'h000000, bank_rd};
   else if (cfg_ok)
      rd_word = {24'h000000, cfg_reg[cfg_slot]};
end

reg pready_next;
reg [31:0] prdata_next;
reg pslverr_next;

always @*
begin
   pready_next = 1'b0;
   prdata_next = 32'h00000000;
   pslverr_next = 1'b0;
   if (setup_ph)
   begin
      pready_next = 1'b1;
      // writes answer with zero data so prdata stays quiet
      if (!pwrite)
         prdata_next = rd_word;
      pslverr_next = !mapped;
   end
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
   end
   else
   begin
      pready <= pready_next;
      prdata <= prdata_next;
      pslverr <= pslverr_next;
   end
end

// pin drive: function mux, polarity, open drain
reg [47:0] out_next;
reg [47:0] oe_next;
reg [95:0] fn_next;
reg [1:0] fn;
reg val;
reg en;
integer n;

always @*
begin
   out_next = 48'h000000000000;
   oe_next = 48'h000000000000;
   fn_next = 96'h000000000000000000000000;
   fn = `GPD_FN_GPIO;
   val = 1'b0;
   en = 1'b0;
   for (n = 0; n < 48; n = n + 1)
   begin
      fn = cfg_reg[n][`GPD_CFG_FN_HI:`GPD_CFG_FN_LO];
      if (fn == `GPD_FN_GPIO)
      begin
         val = data_reg[n] ^ pol[n];
         en = !is_input[n];
      end
      else
      begin
         val = alt_dout[alt_bit(n, fn)] ^ pol[n];
         en = alt_doe[alt_bit(n, fn)];
      end
      // open drain drives low only, floats for a high
      if (cfg_reg[n][`GPD_CFG_OD])
      begin
         oe_next[n] = VALID[n] & en & !val;
         out_next[n] = 1'b0;
      end
      else
      begin
         oe_next[n] = VALID[n] & en;
         out_next[n] = VALID[n] & val;
      end
      fn_next[2 * n +: 2] = VALID[n] ? fn : `GPD_FN_GPIO;
   end
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pin_out <= 48'h000000000000;
      pin_oe <= 48'h000000000000;
      pin_level <= 48'h000000000000;
      pin_fn <= 96'h000000000000000000000000;
   end
   else
   begin
      pin_out <= out_next;
      pin_oe <= oe_next;
      // alternate functions see the raw synchronised level
      pin_level <= pin_sync & VALID;
      pin_fn <= fn_next;
   end
end

endmodule // gpd_bank

// >>> rtl/gpd_consts.vh
// constants for the pin data register bank: indices, field positions, resets
// assumes inclusion by bare name from every design file that decodes registers
`ifndef GPD_CONSTS_VH
`define GPD_CONSTS_VH

// register indices relative to the power event block base (byte address = 4 x index)
`define GPD_IDX_BANK_ONE 10'h04B
`define GPD_IDX_BANK_TWO 10'h04C
`define GPD_IDX_BANK_THREE 10'h04D
`define GPD_IDX_BANK_FOUR 10'h04E
`define GPD_IDX_BANK_FIVE 10'h04F
`define GPD_IDX_BANK_SIX 10'h050
`define GPD_IDX_CFG_FIRST 10'h010
`define GPD_IDX_CFG_LAST 10'h03F

// absolute index of the base register itself, and its reset value
`define GPD_IDX_BASE_REG 10'h3FF
`define GPD_BASE_RESET 10'h100

// configuration register fields
`define GPD_CFG_DIR 0
`define GPD_CFG_POL 1
`define GPD_CFG_FN_LO 2
`define GPD_CFG_FN_HI 3
`define GPD_CFG_OD 7
`define GPD_CFG_RESET 8'h01
`define GPD_CFG_RESET_IR 8'h05

// function select codes
`define GPD_FN_GPIO 2'h0

// slots whose default function is the infrared receiver and transmitter
`define GPD_SLOT_IR_RX 20
`define GPD_SLOT_IR_TX 21

// slot layout: 6 banks of 8 bits, reserved slots cleared in the mask
`define GPD_BANKS 6
`define GPD_SLOTS 48
`define GPD_VALID_MASK 48'h03FF0FFFF7FF

`endif

// >>> rtl/gpd_sync.v
// two-flop synchroniser for a bus of independent pin levels
// assumes each bit is unrelated to the others; no word coherence is promised
`timescale 1ns/100ps

module gpd_sync #(
   parameter W = 48
)
(
   // clock and reset
   input wire clk,
   input wire rst_n,
   // levels
   input wire [W-1:0] d_async,
   output reg [W-1:0] q_sync
);

reg [W-1:0] meta_reg;

always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      meta_reg <= {W{1'b0}};
      q_sync <= {W{1'b0}};
   end
   else
   begin
      meta_reg <= d_async;
      q_sync <= meta_reg;
   end
end

endmodule // gpd_sync

// >>> tb/gpd_bank_properties.sv
// concurrent checks on the ports of the pin data register bank
// assumes binding onto gpd_bank; base register left at its reset value
`timescale 1ns/100ps
`include "gpd_consts.vh"

module gpd_bank_properties #(
   parameter ADDR_W = 12
)
(
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // pins
   input wire [47:0] pin_out,
   input wire [47:0] pin_oe,
   input wire [47:0] pin_level,
   input wire [95:0] pin_fn
);
   wire wr = psel && penable && pwrite;
   // alternates move their own enables, so only gpio slots need a write
   logic [47:0] gpio_mask;
   always_comb
   begin
      for (int s = 0; s < 48; s++)
         gpio_mask[s] = (pin_fn[2 * s +: 2] == 2'b00);
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ONE_WAIT: assert property (psel && !penable |=> pready)
      else $error("no answer one cycle after setup");
   AST_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   AST_BANK_MAPPED: assert property (pready && paddr >= 12'h52C && paddr <= 12'h540
      |-> !pslverr)
      else $error("data bank refused");
   AST_UPPER_ZERO: assert property (pready && paddr[ADDR_W-1:2] != `GPD_IDX_BASE_REG
      |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_RSVD_SLOTS: assert property (((pin_out | pin_oe | pin_level) & ~`GPD_VALID_MASK)
      == 48'h0)
      else $error("reserved slot active");
   AST_OE_CAUSE: assert property ($changed(pin_oe & gpio_mask) |-> $past(wr) || $past(wr, 2)
      || $past(wr, 3))
      else $error("enable moved without write");
   AST_OUT_CAUSE: assert property ($changed(pin_out & pin_oe & gpio_mask) |-> $past(wr)
      || $past(wr, 2)
      || $past(wr, 3))
      else $error("drive moved without write");
   COV_WRITE: cover property (wr && pready && !pslverr);
   COV_READ: cover property (psel && penable && !pwrite && pready);
   COV_ERR: cover property (pslverr);
endmodule // gpd_bank_properties

// >>> tb/tb_gpd_bank.sv
// directed bench for the pin data register bank over apb
// assumes base register at reset value, so bank one sits at byte 0x52C
`timescale 1ns/100ps
`include "gpd_consts.vh"

module tb_gpd_bank;
   localparam [11:0] BANK = 12'h52C;
   localparam [11:0] CFG = 12'h440;
   localparam [47:0] PINS = 48'hF0A55A3CC369;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [47:0] pin_in = PINS;
   logic [143:0] alt_dout = {144{1'b1}};
   logic [143:0] alt_doe = {144{1'b1}};
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [47:0] pin_out;
   wire [47:0] pin_oe;
   wire [47:0] pin_level;
   wire [95:0] pin_fn;
   logic [31:0] rd;
   logic er;
   int num_errors = 0;
   int check_count = 0;

   gpd_bank #(.ADDR_W(12)) u_gpd_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .alt_dout(alt_dout), .alt_doe(alt_doe),
      .pin_level(pin_level), .pin_fn(pin_fn));

   initial
   begin
      forever #4 pclk = ~pclk;
   end

   task chk(input logic [47:0] seen, input logic [47:0] exp, input string nm);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // idle edge first so a release and a new setup never share a time step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task t_banks;
      chk(pin_level, PINS & `GPD_VALID_MASK, "level");
      for (int b = 0; b < 6; b++)
      begin
         apb(1'b0, BANK + 12'(4 * b), 32'h0);
         chk(rd, 48'((PINS & `GPD_VALID_MASK) >> (8 * b)) & 48'hFF, "bank");
         chk(er, 1'b0, "bank err");
      end
   endtask

   task t_output;
      apb(1'b1, CFG, 32'h0);
      apb(1'b1, BANK, 32'hFE);
      // slot one turns output unread, so a landed write would show as bit one
      apb(1'b1, CFG + 12'h4, 32'h0);
      apb(1'b0, BANK, 32'h0);
      chk(rd, 48'h68, "out read");
      repeat (2) @(posedge pclk);
      chk({pin_oe[0], pin_out[0]}, 2'b10, "drive low");
      apb(1'b1, BANK, 32'h01);
      apb(1'b0, BANK, 32'h0);
      chk(rd, 48'h69, "out read 1");
      repeat (2) @(posedge pclk);
      chk(pin_out[0], 1'b1, "drive high");
   endtask

   task t_polarity;
      apb(1'b1, CFG, 32'h02);
      apb(1'b1, CFG + 12'h8, 32'h03);
      repeat (4) @(posedge pclk);
      chk(pin_out[0], 1'b0, "inverted drive");
      apb(1'b0, BANK, 32'h0);
      chk(rd, 48'h6D, "inverted input");
   endtask

   task t_errors;
      apb(1'b0, 12'h000, 32'h0);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped");
      apb(1'b1, CFG + 12'h2C, 32'h00);
      chk(er, 1'b1, "reserved cfg");
   endtask

   task t_function;
      chk({pin_fn[43:40], pin_fn[7:6]}, 6'h14, "fn reset");
      apb(1'b1, CFG + 12'hC, 32'h04);
      repeat (4) @(posedge pclk);
      chk({pin_fn[7:6], pin_oe[3], pin_out[3]}, 4'h7, "alternate");
      apb(1'b1, CFG + 12'hC, 32'h01);
      repeat (2) @(posedge pclk);
      chk(pin_fn[7:6], 2'h0, "fn back");
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      num_errors++;
      summarize();
   end

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_function();
      t_banks();
      t_output();
      t_polarity();
      t_errors();
      summarize();
   end
endmodule // tb_gpd_bank

bind gpd_bank gpd_bank_properties #(.ADDR_W(ADDR_W)) u_gpd_bank_properties (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
   .pin_oe(pin_oe), .pin_level(pin_level), .pin_fn(pin_fn));
